// >>> fpllc_regs.svh
// register offsets, field positions, reset values and lock-detect counts
// included by the loop configuration design files; definitions only
`ifndef FPLLC_REGS_SVH
`define FPLLC_REGS_SVH

// ************************************************
// register addresses on the control port
// ************************************************
`define FPLLC_ADDR_SUPPLY 16'h4001
`define FPLLC_ADDR_LOOP 16'h4002

// ************************************************
// loop_multiplier_control layout (48 bits)
// ************************************************
`define FPLLC_LOOP_BYTES 3'h6
`define FPLLC_LOOP_LAST 3'h5
`define FPLLC_DENOM_HI 47
`define FPLLC_DENOM_LO 32
`define FPLLC_NUMER_HI 31
`define FPLLC_NUMER_LO 16
`define FPLLC_MULT_HI 14
`define FPLLC_MULT_LO 11
`define FPLLC_XDIV_HI 10
`define FPLLC_XDIV_LO 9
`define FPLLC_FRAC_BIT 8
`define FPLLC_LOCK_BIT 1
`define FPLLC_EN_BIT 0
`define FPLLC_LOOP_RESET 48'h0753_0287_1900
// settings struct at reset: denom, numer, mult 3, no input division, fractional, disabled
`define FPLLC_CFG_RESET 40'h07_5302_8732

// ************************************************
// core_supply_level layout (8 bits)
// ************************************************
`define FPLLC_SUP_HI 2
`define FPLLC_SUP_LO 1
`define FPLLC_SUP_RESET 2'h1

// ************************************************
// lock detection
// ************************************************
`define FPLLC_LOCK_WIN 16'h0040
`define FPLLC_LOCK_GOOD 3'h4
`define FPLLC_LOCK_TOL 16'h0001

`endif

// >>> fpllc_pkg.sv
// types shared by the loop configuration top and its feedback divider
// assumes fpllc_regs.svh is compiled alongside
`default_nettype none
package fpllc_pkg;

    typedef struct packed {
        logic [15:0] denom;
        logic [15:0] numer;
        logic [3:0] mult;
        logic [1:0] in_div;
        logic frac;
        logic en;
    } fpllc_cfg_s;

    typedef struct packed {
        logic [3:0] cnt;
        logic [15:0] acc;
        logic [3:0] target;
        logic pulse;
    } fpllc_fb_st_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [2:0] idx;
        logic [39:0] shadow;
        fpllc_cfg_s cfg;
        logic [1:0] supply;
        logic locked;
        logic [7:0] rdata;
        logic [1:0] ref_sync;
        logic ref_prev;
        logic [1:0] loop_sync;
        logic loop_prev;
        logic [1:0] xcnt;
        logic xpulse;
        logic [15:0] win_cnt;
        logic [15:0] fb_cnt;
        logic [2:0] good;
        logic restart;
    } fpllc_st_s;

endpackage
`default_nettype wire

// >>> fpllc_fbdiv.sv
// feedback divider: divides loop clock ticks by R + N/M
// assumes tick is a one-cycle pulse already synchronised to core_clk
`timescale 1ns/1ps
`default_nettype none
`include "fpllc_regs.svh"

module fpllc_fbdiv
    import fpllc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire fpllc_cfg_s cfg,
    input wire logic restart,
    input wire logic tick,
    output logic pulse
);

    fpllc_fb_st_s st;
    fpllc_fb_st_s next_st;
    logic [16:0] sum;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        next_st = st;
        next_st.pulse = 1'b0;
        sum = {1'b0, st.acc} + {1'b0, cfg.numer};
        if (restart) begin
            next_st.cnt = 4'h0;
            next_st.acc = 16'h0000;
            next_st.target = cfg.mult;
        end else if (tick) begin
            if (st.cnt + 4'h1 >= st.target) begin
                next_st.cnt = 4'h0;
                next_st.pulse = 1'b1;
                next_st.target = cfg.mult;
                // zero denominator would wrap on every pulse; run as integer instead
                if (cfg.frac && cfg.denom != 16'h0000) begin
                    if (sum >= {1'b0, cfg.denom}) begin
                        next_st.acc = 16'(sum - {1'b0, cfg.denom});
                        next_st.target = 4'(cfg.mult + 4'h1);
                    end else begin
                        next_st.acc = sum[15:0];
                    end
                end
            end else begin
                next_st.cnt = 4'(st.cnt + 4'h1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pulse = st.pulse;

endmodule
`default_nettype wire

// >>> fpllc_top.sv
// loop configuration and status registers with lock detection
// assumes a byte-wide control port on core_clk; clock pins are asynchronous
// pin edges must come slower than half of core_clk to be counted
// Operation
// - numerator is bits 31:24 then 23:16
// - reference divided by input divider first
// - divider codes: none, two, three, four
// - bit 8 picks fractional or integer
// - fractional mode divides loop by R+N/M
// - bit 1 read-only lock flag
// - bit 0 enables the loop
// - regulator level codes, reset value 01
`timescale 1ns/1ps
`default_nettype none
`include "fpllc_regs.svh"

module fpllc_top
    import fpllc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cp_start,
    input wire logic [15:0] cp_addr,
    input wire logic cp_wr,
    input wire logic [7:0] cp_wdata,
    input wire logic cp_rd,
    output logic [7:0] cp_rdata,
    input wire logic ref_clk_pin,
    input wire logic loop_clk_pin,
    output fpllc_cfg_s loop_cfg,
    output logic loop_locked,
    output logic [1:0] core_supply_output
);

    fpllc_st_s st;
    fpllc_st_s next_st;
    logic loop_tick;
    logic ref_edge;
    logic div_done;
    logic loop_slot;
    logic supply_slot;
    logic burst_done;
    logic win_end;
    logic win_good;
    logic lock_set;
    logic fb_pulse;
    logic [47:0] loop_view;
    logic [47:0] wr_word;
    logic [15:0] diff;

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [7:0] byte_at(input logic [47:0] w, input logic [2:0] i);
        logic [5:0] sh;
        sh = 6'(8 * (`FPLLC_LOOP_LAST - i));
        byte_at = 8'(w >> sh);
    endfunction

    function automatic logic is_loop(input logic [15:0] a);
        is_loop = (a == `FPLLC_ADDR_LOOP);
    endfunction

    function automatic logic is_supply(input logic [15:0] a);
        is_supply = (a == `FPLLC_ADDR_SUPPLY);
    endfunction

    // picks the loop settings out of a full register word
    function automatic fpllc_cfg_s cfg_of(input logic [47:0] w);
        fpllc_cfg_s c;
        c.denom = w[`FPLLC_DENOM_HI:`FPLLC_DENOM_LO];
        c.numer = w[`FPLLC_NUMER_HI:`FPLLC_NUMER_LO];
        c.mult = w[`FPLLC_MULT_HI:`FPLLC_MULT_LO];
        c.in_div = w[`FPLLC_XDIV_HI:`FPLLC_XDIV_LO];
        c.frac = w[`FPLLC_FRAC_BIT];
        c.en = w[`FPLLC_EN_BIT];
        cfg_of = c;
    endfunction

    // ************************************************
    // pin edges and port decode
    // ************************************************
    // pins are read only through the second flop of their synchroniser
    assign ref_edge = st.ref_sync[1] & ~st.ref_prev;
    assign loop_tick = st.loop_sync[1] & ~st.loop_prev;
    assign div_done = st.xcnt >= st.cfg.in_div;
    assign loop_slot = is_loop(st.addr) && st.idx < `FPLLC_LOOP_BYTES;
    assign supply_slot = is_supply(st.addr) && st.idx == 3'h0;
    // the sixth byte of a loop burst commits the whole word
    assign burst_done = loop_slot && st.idx == `FPLLC_LOOP_LAST;

    fpllc_fbdiv u_fbdiv (
        .core_clk(core_clk),
        .nrst(nrst),
        .cfg(st.cfg),
        .restart(st.restart),
        .tick(loop_tick),
        .pulse(fb_pulse)
    );

    // reserved positions are forced to zero on read
    assign loop_view = {st.cfg.denom, st.cfg.numer, 1'b0, st.cfg.mult,
        st.cfg.in_div, st.cfg.frac, 6'h00, st.locked, st.cfg.en};
    assign wr_word = {st.shadow, cp_wdata};
    assign diff = (st.fb_cnt > `FPLLC_LOCK_WIN) ? 16'(st.fb_cnt - `FPLLC_LOCK_WIN)
        : 16'(`FPLLC_LOCK_WIN - st.fb_cnt);
    assign win_end = st.win_cnt == 16'(`FPLLC_LOCK_WIN - 16'h0001);
    // one feedback pulse of slack absorbs synchroniser phase
    assign win_good = diff <= `FPLLC_LOCK_TOL;
    assign lock_set = st.good >= `FPLLC_LOCK_GOOD;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        next_st = st;
        next_st.xpulse = 1'b0;
        next_st.ref_sync = {st.ref_sync[0], ref_clk_pin};
        next_st.ref_prev = st.ref_sync[1];
        // both pin synchronisers shift on every cycle
        next_st.loop_sync = {st.loop_sync[0], loop_clk_pin};
        next_st.loop_prev = st.loop_sync[1];
        next_st.restart = ~st.cfg.en;

        // control port
        if (cp_start) begin
            next_st.addr = cp_addr;
            next_st.idx = 3'h0;
        end else if (cp_wr) begin
            if (loop_slot) begin
                next_st.idx = 3'(st.idx + 3'h1);
                // only a complete burst takes effect, never a partial one
                if (burst_done) begin
                    next_st.cfg = cfg_of(wr_word);
                    // a new setting must prove lock again from scratch
                    next_st.restart = 1'b1;
                end else begin
                    next_st.shadow = 40'({st.shadow[31:0], cp_wdata});
                end
            end else if (supply_slot) begin
                next_st.supply = cp_wdata[`FPLLC_SUP_HI:`FPLLC_SUP_LO];
                next_st.idx = 3'h1;
            end
        end else if (cp_rd) begin
            next_st.rdata = 8'h00;
            if (loop_slot) begin
                next_st.rdata = byte_at(loop_view, st.idx);
            end else if (supply_slot) begin
                next_st.rdata = {5'h00, st.supply, 1'b0};
            end
            next_st.idx = (st.idx < `FPLLC_LOOP_BYTES) ? 3'(st.idx + 3'h1) : st.idx;
        end

        // input divider: code n counts n+1 reference edges
        if (ref_edge) begin
            if (div_done) begin
                next_st.xcnt = 2'h0;
                next_st.xpulse = 1'b1;
            end else begin
                next_st.xcnt = 2'(st.xcnt + 2'h1);
            end
        end

        // lock detect: feedback pulses per window of divided reference
        if (st.restart) begin
            next_st.win_cnt = 16'h0000;
            next_st.fb_cnt = 16'h0000;
            next_st.good = 3'h0;
            next_st.locked = 1'b0;
        end else begin
            if (fb_pulse && st.fb_cnt != 16'hFFFF) begin
                next_st.fb_cnt = 16'(st.fb_cnt + 16'h0001);
            end
            if (st.xpulse) begin
                if (win_end) begin
                    next_st.win_cnt = 16'h0000;
                    // a pulse on the closing edge belongs to the next window
                    next_st.fb_cnt = {15'h0000, fb_pulse};
                    if (win_good) begin
                        next_st.good = (st.good < `FPLLC_LOCK_GOOD)
                            ? 3'(st.good + 3'h1) : st.good;
                    end else begin
                        next_st.good = 3'h0;
                    end
                end else begin
                    next_st.win_cnt = 16'(st.win_cnt + 16'h0001);
                end
            end
            // sticky once reached; cleared only by disable or a new burst
            if (lock_set) begin
                next_st.locked = 1'b1;
            end
        end
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            // settings come up with the loop disabled
            st.cfg <= `FPLLC_CFG_RESET;
            st.supply <= `FPLLC_SUP_RESET;
            st.restart <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign cp_rdata = st.rdata;
    assign loop_cfg = st.cfg;
    assign loop_locked = st.locked;
    assign core_supply_output = st.supply;

endmodule
`default_nettype wire

// >>> fpllc_checker.sv
// port-level assertions for the loop configuration top
// assumes fpllc_pkg is compiled first; bound into fpllc_top below
`timescale 1ns/1ps
`default_nettype none
module fpllc_checker
    import fpllc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cp_start,
    input wire logic [15:0] cp_addr,
    input wire logic cp_wr,
    input wire logic [7:0] cp_wdata,
    input wire logic cp_rd,
    input wire logic [7:0] cp_rdata,
    input wire logic ref_clk_pin,
    input wire logic loop_clk_pin,
    input wire fpllc_cfg_s loop_cfg,
    input wire logic loop_locked,
    input wire logic [1:0] core_supply_output
);
    // ****
    // checks
    // ****
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence loop_open;
        cp_start && cp_addr == 16'h4002;
    endsequence
    chk_cfg_cause: assert property (!$stable(loop_cfg) |-> $past(cp_wr))
        else $error("loop settings moved without a write");
    chk_supply_cause: assert property (!$stable(core_supply_output) |-> $past(cp_wr))
        else $error("supply level moved without a write");
    chk_supply_write: assert property (
        (cp_start && cp_addr == 16'h4001) ##1 (cp_wr && !cp_start)
        |=> core_supply_output == $past(cp_wdata[2:1]))
        else $error("supply level not taken from first byte");
    chk_lock_en: assert property ($rose(loop_locked) |-> loop_cfg.en)
        else $error("lock rose while loop disabled");
    chk_lock_drop: assert property ($fell(loop_cfg.en) |-> ##[0:2] !loop_locked)
        else $error("lock kept after disable");
    chk_unmapped_zero: assert property (
        (cp_start && cp_addr == 16'h4000) ##1 (cp_rd && !cp_start) |=> cp_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_lock_read: assert property (
        loop_open ##1 (cp_rd && !cp_start)[*6]
        |=> cp_rdata == {6'h00, $past(loop_locked), $past(loop_cfg.en)})
        else $error("status byte wrong");
    chk_ratio_fields: assert property (
        loop_open ##1 (cp_wr && !cp_start)[*6]
        |=> loop_cfg.denom == {$past(cp_wdata, 6), $past(cp_wdata, 5)}
        && loop_cfg.numer == {$past(cp_wdata, 4), $past(cp_wdata, 3)})
        else $error("ratio fields misassembled");
    cover property ($rose(loop_locked));
    cover property (loop_open ##1 (cp_wr && !cp_start)[*6]);
    cover property ($fell(loop_cfg.en));
endmodule

bind fpllc_top fpllc_checker chk_u (.core_clk(core_clk), .nrst(nrst), .cp_start(cp_start),
    .cp_addr(cp_addr), .cp_wr(cp_wr), .cp_wdata(cp_wdata), .cp_rd(cp_rd),
    .cp_rdata(cp_rdata), .ref_clk_pin(ref_clk_pin), .loop_clk_pin(loop_clk_pin),
    .loop_cfg(loop_cfg), .loop_locked(loop_locked), .core_supply_output(core_supply_output));
`default_nettype wire

// >>> fpllc_tb.sv
// self-checking bench for the loop configuration top
// assumes fpllc_pkg, the design and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module tb;
    import fpllc_pkg::*;
    logic core_clk = 0, nrst = 0, cp_start = 0, cp_wr = 0, cp_rd = 0, run = 0;
    logic ref_clk_pin = 0, loop_clk_pin = 0;
    logic [15:0] cp_addr = 16'h0000;
    logic [7:0] cp_wdata = 8'h00;
    logic [7:0] cp_rdata;
    fpllc_cfg_s loop_cfg;
    logic loop_locked;
    logic [1:0] core_supply_output;
    int error_cnt = 0, checked = 0;
    realtime ref_half = 160;

    // ****
    // clocks and design
    // ****
    always #5 core_clk = ~core_clk;
    // pins rest low while idle so no stray edge reaches the counters
    always #(ref_half) ref_clk_pin = run ? ~ref_clk_pin : 1'b0;
    always #40 loop_clk_pin = run ? ~loop_clk_pin : 1'b0;

    fpllc_top dut_u (.core_clk(core_clk), .nrst(nrst), .cp_start(cp_start), .cp_addr(cp_addr),
        .cp_wr(cp_wr), .cp_wdata(cp_wdata), .cp_rd(cp_rd), .cp_rdata(cp_rdata),
        .ref_clk_pin(ref_clk_pin), .loop_clk_pin(loop_clk_pin), .loop_cfg(loop_cfg),
        .loop_locked(loop_locked), .core_supply_output(core_supply_output));

    // ****
    // port tasks
    // ****
    task automatic cyc;
        @(posedge core_clk);
        #1;
    endtask

    // bytes go msb first; bytes past the sixth carry zero
    task automatic burst(input logic [15:0] a, input logic [47:0] v, input int n,
        input logic rd);
        cp_start = 1'b1;
        cp_addr = a;
        cyc();
        cp_start = 1'b0;
        for (int i = 0; i < n; i++) begin
            cp_wr = !rd;
            cp_rd = rd;
            cp_wdata = (i < 6) ? v[47 - 8 * i -: 8] : 8'h00;
            cyc();
            if (rd) `CHK(cp_rdata, cp_wdata)
        end
        cp_wr = 1'b0;
        cp_rd = 1'b0;
    endtask

    task automatic test_done;
        $display("errors %0d, checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wait_lock;
        int n;
        n = 0;
        // a finished burst drops the old lock one cycle later
        repeat (2) cyc();
        `CHK(loop_locked, 1'b0)
        while (loop_locked !== 1'b1 && n < 20000) begin
            cyc();
            n++;
        end
        `CHK(loop_locked, 1'b1)
        if (n == 20000) test_done();
    endtask

    // ****
    // sequence
    // ****
    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        `CHK(loop_cfg, {32'h0753_0287, 4'h3, 2'h0, 2'b10})
        `CHK(core_supply_output, 2'h1)
        burst(16'h4002, 48'h0753_0287_1900, 7, 1'b1);
        burst(16'h4001, 48'h0200_0000_0000, 1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            burst(16'h4001, {5'h1F, i[1:0], 1'b1, 5'h00, ~i[1:0], 1'b0, 32'h0}, 2, 1'b0);
            `CHK(core_supply_output, i[1:0])
            burst(16'h4001, {5'h00, i[1:0], 1'b0, 40'h0}, 1, 1'b1);
        end
        burst(16'h4000, 48'hFFFF_FFFF_FFFF, 1, 1'b0);
        burst(16'h4000, 48'h0, 1, 1'b1);
        for (int x = 0; x < 4; x++) begin
            burst(16'h4002, {32'h007D_000C, 1'b1, 4'h4, x[1:0], 1'b0, 8'hFE}, 6, 1'b0);
            cyc();
            `CHK(loop_cfg, {32'h007D_000C, 4'h4, x[1:0], 2'b00})
            burst(16'h4002, {32'h007D_000C, 1'b0, 4'h4, x[1:0], 9'h0}, 7, 1'b1);
        end
        // cut short by a fresh start, so nothing may land
        burst(16'h4002, 48'hFFFF_FFFF_FFFF, 3, 1'b0);
        burst(16'h4001, 48'h0600_0000_0000, 1, 1'b1);
        `CHK(loop_cfg, {32'h007D_000C, 4'h4, 2'h3, 2'b00})
        run = 1'b1;
        burst(16'h4002, 48'h007D_0000_2001, 6, 1'b0);
        wait_lock();
        burst(16'h4002, 48'h007D_0000_2003, 6, 1'b1);
        ref_half = 90;
        burst(16'h4002, 48'h0002_0001_2301, 6, 1'b0);
        wait_lock();
        burst(16'h4002, 48'h0002_0001_2302, 6, 1'b0);
        repeat (3) cyc();
        `CHK(loop_locked, 1'b0)
        burst(16'h4002, 48'h0002_0001_2300, 6, 1'b1);
        run = 1'b0;
        test_done();
    end
endmodule
`default_nettype wire
